// ---- core/crs_pkg.sv ----
// Package of constants and carrier types for the return/rotate/subtract/sleep execution unit.
package crs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W   = 11;
  localparam int NIB_W  = 4;

  // ----------------------------------------------------------------
  // Register map of the plain register port (word index)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_ACC    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_WDOG   = 4'h2;
  localparam logic [3:0] REG_PRESC  = 4'h3;
  localparam logic [3:0] REG_CTRL   = 4'h4;

  // Status bit positions.
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;

  // ----------------------------------------------------------------
  // Reset values and other constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [7:0]  WDOG_CLR   = 8'h00;
  localparam logic [7:0]  PRESC_CLR  = 8'h00;
  localparam logic [10:0] PC_RST     = 11'h000;
  localparam logic [7:0]  ZERO8      = 8'h00;
  localparam logic [7:0]  PRESC_MAX  = 8'hFF;
  localparam logic [7:0]  CNT_STEP   = 8'h01;

  // ----------------------------------------------------------------
  // Operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CRS_OP_NONE  = 3'b000,
    CRS_OP_RETLT = 3'b001,
    CRS_OP_ROTR  = 3'b010,
    CRS_OP_LSUB  = 3'b011,
    CRS_OP_RSUB  = 3'b100,
    CRS_OP_SLEEP = 3'b101
  } crs_op_e;

  typedef enum logic [1:0] {
    CRS_ST_RUN    = 2'b00,
    CRS_ST_RET2   = 2'b01,
    CRS_ST_HALTED = 2'b10
  } crs_state_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    crs_op_e           op;
    logic [ADDR_W-1:0] raddr;
    logic              dest;
    logic [DATA_W-1:0] lit;
  } crs_instr_s;

  typedef struct packed {
    logic [DATA_W-1:0] res;
    logic              c;
    logic              dc;
    logic              z;
  } crs_alu_s;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } crs_fwr_s;

endpackage

// ---- core/crs_alu.sv ----
// Combinational subtract and rotate datapath of the execution unit.
`timescale 1ns/1ns
module crs_alu (
  input  wire logic [7:0]       a_in,
  input  wire logic [7:0]       acc,
  input  wire logic             carry_in,
  input  wire logic             rotate,
  output crs_pkg::crs_alu_s     result
);
  logic [8:0] diff;
  logic [4:0] ndiff;

  always_comb begin
    diff  = {1'b0, a_in} - {1'b0, acc};
    ndiff = {1'b0, a_in[3:0]} - {1'b0, acc[3:0]};
    result = '0;
    if (rotate) begin
      // RULE_04: rotate through carry
      result.res = {carry_in, a_in[7:1]};
      result.c   = a_in[0];
    end else begin
      // RULE_07: borrow flags inverted
      result.res = diff[7:0];
      result.c   = ~diff[8];
      result.dc  = ~ndiff[4];
      // RULE_13: zero flag
      result.z   = (diff[7:0] == crs_pkg::ZERO8);
    end
  end
endmodule

// ---- core/crs_exec.sv ----
// Execution unit for return-with-literal, rotate right, both subtracts and sleep.
// Summary of operation
// RULE_01: Return loads literal into accumulator.
// RULE_02: Return pops stack head into program counter.
// RULE_03: Return takes two instruction cycles.
// RULE_04: Rotate right through carry, only carry changes.
// RULE_05: Register address 0-127, destination bit selects.
// RULE_06: Literal minus accumulator updates C, DC, Z.
// RULE_07: Carry and half borrow are inverted borrows.
// RULE_08: Register minus accumulator, same flag rules.
// RULE_09: Register subtract result goes per destination bit.
// RULE_10: Sleep clears watchdog counter and prescaler.
// RULE_11: Sleep clears powerdown, sets expiry flag.
// RULE_12: Sleep halts execution, oscillator stopped.
// RULE_13: Zero flag reflects subtraction result.
`timescale 1ns/1ns
module crs_exec (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire crs_pkg::crs_instr_s  instr,
  input  wire logic [7:0]           file_rdata,
  input  wire logic [10:0]          stack_head,
  input  wire logic                 wake,
  input  wire logic                 wdog_tick,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  output logic [6:0]                file_raddr,
  output crs_pkg::crs_fwr_s         file_wr,
  output logic                      stack_pop,
  output logic                      pc_load,
  output logic [10:0]               pc_value,
  output logic                      busy,
  output logic                      osc_stop
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    crs_pkg::crs_state_e state;
    logic [7:0]          acc;
    logic [7:0]          status;
    logic [7:0]          wdog;
    logic [7:0]          presc;
    logic [7:0]          rdata;
    crs_pkg::crs_fwr_s   fwr;
    logic                pop;
    logic                pcl;
    logic [10:0]         pcv;
    logic                osc_stop;
    logic                busy;
  } crs_state_s;

  crs_state_s        cur;
  crs_state_s        next_cur;
  crs_pkg::crs_alu_s alu;
  logic [7:0]        alu_a;

  // The register operand arrives combinationally from the file, so the
  // read address is driven straight from the decoded instruction.
  assign file_raddr = instr.raddr;
  assign alu_a = (instr.op == crs_pkg::CRS_OP_LSUB) ? instr.lit : file_rdata;

  crs_alu u_alu (
    .a_in     (alu_a),
    .acc      (cur.acc),
    .carry_in (cur.status[crs_pkg::ST_C]),
    .rotate   (instr.op == crs_pkg::CRS_OP_ROTR),
    .result   (alu)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur        = cur;
    next_cur.fwr.we = 1'b0;
    next_cur.pop    = 1'b0;
    next_cur.pcl    = 1'b0;
    next_cur.rdata  = crs_pkg::ZERO8;

    // The watchdog counts while awake; a tick is ignored while halted.
    if (wdog_tick && cur.state != crs_pkg::CRS_ST_HALTED) begin
      next_cur.presc = cur.presc + crs_pkg::CNT_STEP;
      if (cur.presc == crs_pkg::PRESC_MAX) begin
        next_cur.wdog = cur.wdog + crs_pkg::CNT_STEP;
      end
    end

    unique case (cur.state)
      crs_pkg::CRS_ST_RUN: begin
        if (instr.valid) begin
          unique case (instr.op)
            crs_pkg::CRS_OP_RETLT: begin
              // RULE_01: literal into accumulator
              next_cur.acc = instr.lit;
              // RULE_02: pop stack head into pc
              next_cur.pop = 1'b1;
              next_cur.pcl = 1'b1;
              next_cur.pcv = stack_head;
              // RULE_03: second cycle follows
              next_cur.state = crs_pkg::CRS_ST_RET2;
            end
            crs_pkg::CRS_OP_ROTR, crs_pkg::CRS_OP_RSUB: begin
              // RULE_05: destination bit selects target
              if (instr.dest) begin
                // RULE_09: result back to register
                next_cur.fwr.we   = 1'b1;
                next_cur.fwr.addr = instr.raddr;
                next_cur.fwr.data = alu.res;
              end else begin
                next_cur.acc = alu.res;
              end
              next_cur.status[crs_pkg::ST_C] = alu.c;
              if (instr.op == crs_pkg::CRS_OP_RSUB) begin
                // RULE_08: subtract flags
                next_cur.status[crs_pkg::ST_DC] = alu.dc;
                next_cur.status[crs_pkg::ST_Z]  = alu.z;
              end
            end
            crs_pkg::CRS_OP_LSUB: begin
              // RULE_06: literal minus accumulator
              next_cur.acc = alu.res;
              next_cur.status[crs_pkg::ST_C]  = alu.c;
              next_cur.status[crs_pkg::ST_DC] = alu.dc;
              next_cur.status[crs_pkg::ST_Z]  = alu.z;
            end
            crs_pkg::CRS_OP_SLEEP: begin
              // RULE_10: clear watchdog and prescaler
              next_cur.wdog  = crs_pkg::WDOG_CLR;
              next_cur.presc = crs_pkg::PRESC_CLR;
              // RULE_11: powerdown clear, expiry set
              next_cur.status[crs_pkg::ST_PD] = 1'b0;
              next_cur.status[crs_pkg::ST_TO] = 1'b1;
              // RULE_12: stop oscillator and halt
              next_cur.osc_stop = 1'b1;
              next_cur.state    = crs_pkg::CRS_ST_HALTED;
            end
            default: begin
            end
          endcase
        end
      end
      crs_pkg::CRS_ST_RET2: begin
        next_cur.state = crs_pkg::CRS_ST_RUN;
      end
      crs_pkg::CRS_ST_HALTED: begin
        if (wake) begin
          next_cur.osc_stop = 1'b0;
          next_cur.state    = crs_pkg::CRS_ST_RUN;
        end
      end
      default: begin
        next_cur.state = crs_pkg::CRS_ST_RUN;
      end
    endcase

    // Software writes land after execution, so they win over it.
    if (reg_wr) begin
      unique case (reg_addr)
        crs_pkg::REG_ACC:    next_cur.acc    = reg_wdata;
        crs_pkg::REG_STATUS: next_cur.status = reg_wdata;
        crs_pkg::REG_WDOG:   next_cur.wdog   = reg_wdata;
        crs_pkg::REG_PRESC:  next_cur.presc  = reg_wdata;
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        crs_pkg::REG_ACC:    next_cur.rdata = cur.acc;
        crs_pkg::REG_STATUS: next_cur.rdata = cur.status;
        crs_pkg::REG_WDOG:   next_cur.rdata = cur.wdog;
        crs_pkg::REG_PRESC:  next_cur.rdata = cur.presc;
        crs_pkg::REG_CTRL:   next_cur.rdata = {6'h00, cur.state};
        default:             next_cur.rdata = crs_pkg::ZERO8;
      endcase
    end

    // Busy is held in a register bit of its own so that the output comes
    // straight from a flip-flop while keeping the timing of the state.
    next_cur.busy = (next_cur.state != crs_pkg::CRS_ST_RUN);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur          <= '0;
      cur.state    <= crs_pkg::CRS_ST_RUN;
      cur.acc      <= crs_pkg::ACC_RST;
      cur.status   <= crs_pkg::STATUS_RST;
      cur.wdog     <= crs_pkg::WDOG_CLR;
      cur.presc    <= crs_pkg::PRESC_CLR;
      cur.pcv      <= crs_pkg::PC_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign file_wr   = cur.fwr;
  assign stack_pop = cur.pop;
  assign pc_load   = cur.pcl;
  assign pc_value  = cur.pcv;
  assign busy      = cur.busy;
  assign osc_stop  = cur.osc_stop;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ret_literal: assert property (@(posedge clk_sys) disable iff (reset) // RULE_01
    (instr.valid && instr.op == crs_pkg::CRS_OP_RETLT && cur.state == crs_pkg::CRS_ST_RUN && !reg_wr)
      |=> cur.acc == $past(instr.lit)) else $error("return literal not loaded");
  a_ret_pop: assert property (@(posedge clk_sys) disable iff (reset) // RULE_02
    (instr.valid && instr.op == crs_pkg::CRS_OP_RETLT && cur.state == crs_pkg::CRS_ST_RUN)
      |=> stack_pop && pc_load && pc_value == $past(stack_head)) else $error("return did not pop");
  a_ret_two_cycle: assert property (@(posedge clk_sys) disable iff (reset) // RULE_03
    (instr.valid && instr.op == crs_pkg::CRS_OP_RETLT && cur.state == crs_pkg::CRS_ST_RUN)
      |=> busy ##1 !busy) else $error("return not two cycles");
  a_rot_carry: assert property (@(posedge clk_sys) disable iff (reset) // RULE_04
    (instr.valid && instr.op == crs_pkg::CRS_OP_ROTR && cur.state == crs_pkg::CRS_ST_RUN && !reg_wr)
      |=> cur.status[crs_pkg::ST_C] == $past(file_rdata[0])
        && cur.status[crs_pkg::ST_Z] == $past(cur.status[crs_pkg::ST_Z])) else $error("rotate carry wrong");
  a_rsub_dest: assert property (@(posedge clk_sys) disable iff (reset) // RULE_09
    (instr.valid && instr.op == crs_pkg::CRS_OP_RSUB && cur.state == crs_pkg::CRS_ST_RUN && instr.dest)
      |=> file_wr.we && file_wr.data == $past(file_rdata - cur.acc)) else $error("subtract dest wrong");
  a_lsub_carry: assert property (@(posedge clk_sys) disable iff (reset) // RULE_07
    (instr.valid && instr.op == crs_pkg::CRS_OP_LSUB && cur.state == crs_pkg::CRS_ST_RUN && !reg_wr)
      |=> cur.status[crs_pkg::ST_C] == ($past(cur.acc) <= $past(instr.lit))) else $error("borrow wrong");
  a_sleep_wdog: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
    (instr.valid && instr.op == crs_pkg::CRS_OP_SLEEP && cur.state == crs_pkg::CRS_ST_RUN && !reg_wr)
      |=> cur.wdog == crs_pkg::WDOG_CLR && cur.presc == crs_pkg::PRESC_CLR) else $error("watchdog not cleared");
  a_sleep_flags: assert property (@(posedge clk_sys) disable iff (reset) // RULE_11
    (instr.valid && instr.op == crs_pkg::CRS_OP_SLEEP && cur.state == crs_pkg::CRS_ST_RUN && !reg_wr)
      |=> !cur.status[crs_pkg::ST_PD] && cur.status[crs_pkg::ST_TO]) else $error("sleep flags wrong");
  a_sleep_halt: assert property (@(posedge clk_sys) disable iff (reset) // RULE_12
    (instr.valid && instr.op == crs_pkg::CRS_OP_SLEEP && cur.state == crs_pkg::CRS_ST_RUN)
      |=> osc_stop && busy) else $error("sleep did not halt");
  c_ret: cover property (@(posedge clk_sys) instr.valid && instr.op == crs_pkg::CRS_OP_RETLT);
  c_rsub_w: cover property (@(posedge clk_sys) instr.valid && instr.op == crs_pkg::CRS_OP_RSUB && !instr.dest);
  c_sleep_wake: cover property (@(posedge clk_sys) osc_stop ##1 wake);
  c_rot_reg: cover property (@(posedge clk_sys) instr.valid && instr.op == crs_pkg::CRS_OP_ROTR && instr.dest);
  c_lsub: cover property (@(posedge clk_sys) instr.valid && instr.op == crs_pkg::CRS_OP_LSUB);

  // ----------------------------------------------------------------
  // Result paths and refused cycles
  // ----------------------------------------------------------------
  // Expected values are rebuilt from the operands of the cycle before,
  // so a broken datapath cannot hide behind its own result.

  a_rot_result: assert property (@(posedge clk_sys) disable iff (reset) // RULE_04
    (instr.valid && instr.op == crs_pkg::CRS_OP_ROTR && cur.state == crs_pkg::CRS_ST_RUN && instr.dest)
      |=> file_wr.we && file_wr.addr == $past(instr.raddr)
        && file_wr.data == {$past(cur.status[crs_pkg::ST_C]), $past(file_rdata[crs_pkg::DATA_W-1:1])}
  ) else $error("rotate result wrong");

  a_rot_keep: assert property (@(posedge clk_sys) disable iff (reset) // RULE_04
    (instr.valid && instr.op == crs_pkg::CRS_OP_ROTR && cur.state == crs_pkg::CRS_ST_RUN && !reg_wr)
      |=> cur.status[crs_pkg::DATA_W-1:crs_pkg::ST_DC] == $past(cur.status[crs_pkg::DATA_W-1:crs_pkg::ST_DC])
  ) else $error("rotate touched other flags");

  a_dest_acc: assert property (@(posedge clk_sys) disable iff (reset) // RULE_05
    (instr.valid && (instr.op == crs_pkg::CRS_OP_ROTR || instr.op == crs_pkg::CRS_OP_RSUB)
      && cur.state == crs_pkg::CRS_ST_RUN && !instr.dest)
      |=> !file_wr.we
  ) else $error("accumulator target wrote file");

  a_lsub_result: assert property (@(posedge clk_sys) disable iff (reset) // RULE_06
    (instr.valid && instr.op == crs_pkg::CRS_OP_LSUB && cur.state == crs_pkg::CRS_ST_RUN && !reg_wr)
      |=> (cur.acc + $past(cur.acc)) == $past(instr.lit) && !file_wr.we
  ) else $error("literal subtract result wrong");

  a_rsub_carry: assert property (@(posedge clk_sys) disable iff (reset) // RULE_08
    (instr.valid && instr.op == crs_pkg::CRS_OP_RSUB && cur.state == crs_pkg::CRS_ST_RUN && !reg_wr)
      |=> cur.status[crs_pkg::ST_C] == ($past(cur.acc) <= $past(file_rdata))
        && cur.status[crs_pkg::ST_DC] == ($past(cur.acc[crs_pkg::NIB_W-1:0]) <= $past(file_rdata[crs_pkg::NIB_W-1:0]))
  ) else $error("register subtract flags wrong");

  a_sub_zero: assert property (@(posedge clk_sys) disable iff (reset) // RULE_13
    (instr.valid && (instr.op == crs_pkg::CRS_OP_LSUB || instr.op == crs_pkg::CRS_OP_RSUB)
      && cur.state == crs_pkg::CRS_ST_RUN && !reg_wr)
      |=> cur.status[crs_pkg::ST_Z] == ($past(alu_a) == $past(cur.acc))
  ) else $error("zero flag wrong");

  a_sleep_keep: assert property (@(posedge clk_sys) disable iff (reset) // RULE_11
    (instr.valid && instr.op == crs_pkg::CRS_OP_SLEEP && cur.state == crs_pkg::CRS_ST_RUN && !reg_wr)
      |=> cur.status[crs_pkg::ST_Z:crs_pkg::ST_C] == $past(cur.status[crs_pkg::ST_Z:crs_pkg::ST_C])
  ) else $error("sleep touched arithmetic flags");

  a_ret2_refuse: assert property (@(posedge clk_sys) disable iff (reset) // RULE_03
    (cur.state == crs_pkg::CRS_ST_RET2)
      |=> !busy && !stack_pop && !pc_load && !file_wr.we
  ) else $error("second return cycle not idle");

  a_halt_refuse: assert property (@(posedge clk_sys) disable iff (reset) // RULE_12
    (cur.state == crs_pkg::CRS_ST_HALTED && !wake)
      |=> busy && osc_stop && !stack_pop && !pc_load && !file_wr.we
  ) else $error("halted core executed");

  a_halt_wdog: assert property (@(posedge clk_sys) disable iff (reset) // RULE_12
    (cur.state == crs_pkg::CRS_ST_HALTED && !reg_wr)
      |=> cur.wdog == $past(cur.wdog) && cur.presc == $past(cur.presc)
  ) else $error("watchdog moved while halted");
endmodule

// ---- bench/crs_exec_tb_top.sv ----
// Self-checking testbench for the return, rotate, subtract and sleep execution unit.
`timescale 1ns/1ns
module crs_exec_tb_top;
  logic                clk_sys;
  logic                reset;
  crs_pkg::crs_instr_s instr;
  logic [7:0]          file_rdata;
  logic [10:0]         stack_head;
  logic                wake;
  logic                wdog_tick;
  logic [3:0]          reg_addr;
  logic [7:0]          reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [7:0]          reg_rdata;
  logic [6:0]          file_raddr;
  crs_pkg::crs_fwr_s   file_wr;
  logic                stack_pop;
  logic                pc_load;
  logic [10:0]         pc_value;
  logic                busy;
  logic                osc_stop;
  int                  err_count;
  int                  checked;
  int                  cyc;
  logic [7:0]          rv;

  crs_exec uut (.clk_sys(clk_sys), .reset(reset), .instr(instr), .file_rdata(file_rdata),
    .stack_head(stack_head), .wake(wake), .wdog_tick(wdog_tick), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .file_raddr(file_raddr), .file_wr(file_wr), .stack_pop(stack_pop), .pc_load(pc_load),
    .pc_value(pc_value), .busy(busy), .osc_stop(osc_stop));

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic exec(input crs_pkg::crs_op_e op, input logic [6:0] a, input logic d, input logic [7:0] k);
    @(posedge clk_sys);
    instr <= {1'b1, op, a, d, k};
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    #1;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [3:0] idx [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5};
    logic [7:0] exp [5] = '{8'h00, 8'h18, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd(idx[i]);
      chk("reset reg", rv, exp[i]);
    end
    chk("busy idle", busy, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_ret();
    stack_head <= 11'h5A3;
    exec(crs_pkg::CRS_OP_RETLT, 7'h00, 1'b0, 8'hFF);
    chk("pop", stack_pop, 1'b1);
    chk("pc load", pc_load, 1'b1);
    chk("pc value", pc_value, 11'h5A3);
    chk("busy c1", busy, 1'b1);
    @(posedge clk_sys);
    #1 chk("busy c2", busy, 1'b0);
    chk("pop c2", stack_pop, 1'b0);
    rd(crs_pkg::REG_ACC);
    chk("ret acc", rv, 8'hFF);
    $display("test return done");
  endtask

  // Subtracts with flags worked out here: C and DC are inverted borrows.
  task automatic sub(input crs_pkg::crs_op_e op, input logic [7:0] a, input logic [7:0] k, input logic d);
    logic [7:0] res;
    res = k - a;
    wr(crs_pkg::REG_ACC, a);
    file_rdata <= k;
    exec(op, 7'h7F, d, k);
    chk("fwr we", file_wr.we, d);
    chk("fwr raddr", file_raddr, 7'h7F);
    if (d) begin
      chk("fwr addr", file_wr.addr, 7'h7F);
      chk("fwr data", file_wr.data, res);
    end
    rd(crs_pkg::REG_ACC);
    chk("acc", rv, d ? a : res);
    rd(crs_pkg::REG_STATUS);
    chk("status", rv, {3'b000, 2'b11, res == 8'h00, a[3:0] <= k[3:0], a <= k});
  endtask

  task automatic t_sub();
    sub(crs_pkg::CRS_OP_LSUB, 8'h05, 8'h05, 1'b0);
    sub(crs_pkg::CRS_OP_LSUB, 8'h04, 8'h03, 1'b0);
    sub(crs_pkg::CRS_OP_LSUB, 8'h01, 8'h10, 1'b0);
    sub(crs_pkg::CRS_OP_RSUB, 8'h30, 8'h25, 1'b1);
    sub(crs_pkg::CRS_OP_RSUB, 8'hA0, 8'hA0, 1'b0);
    sub(crs_pkg::CRS_OP_RSUB, 8'h0F, 8'hF0, 1'b1);
    $display("test subtract done");
  endtask

  task automatic t_rot();
    wr(crs_pkg::REG_STATUS, 8'h1F);
    wr(crs_pkg::REG_ACC, 8'h3C);
    file_rdata <= 8'h02;
    exec(crs_pkg::CRS_OP_ROTR, 7'h05, 1'b1, 8'h00);
    chk("rot we", file_wr.we, 1'b1);
    chk("rot raddr", file_raddr, 7'h05);
    chk("rot data", file_wr.data, 8'h81);
    rd(crs_pkg::REG_STATUS);
    chk("rot status", rv, 8'h1E);
    file_rdata <= 8'h01;
    exec(crs_pkg::CRS_OP_ROTR, 7'h05, 1'b0, 8'h00);
    chk("rot we acc", file_wr.we, 1'b0);
    rd(crs_pkg::REG_ACC);
    chk("rot acc", rv, 8'h00);
    rd(crs_pkg::REG_STATUS);
    chk("rot status2", rv, 8'h1F);
    $display("test rotate done");
  endtask

  task automatic t_sleep();
    wr(crs_pkg::REG_STATUS, 8'h0F);
    wr(crs_pkg::REG_WDOG, 8'h07);
    wr(crs_pkg::REG_PRESC, 8'h05);
    exec(crs_pkg::CRS_OP_SLEEP, 7'h00, 1'b0, 8'h00);
    chk("osc stop", osc_stop, 1'b1);
    chk("halt busy", busy, 1'b1);
    wdog_tick <= 1'b1;
    rd(crs_pkg::REG_STATUS);
    wdog_tick <= 1'b0;
    chk("sleep status", rv, 8'h17);
    rd(crs_pkg::REG_WDOG);
    chk("wdog", rv, 8'h00);
    rd(crs_pkg::REG_PRESC);
    chk("presc", rv, 8'h00);
    rd(crs_pkg::REG_CTRL);
    chk("halt state", rv, {6'h00, crs_pkg::CRS_ST_HALTED});
    // An instruction offered while halted must leave no trace.
    exec(crs_pkg::CRS_OP_ROTR, 7'h01, 1'b1, 8'h00);
    chk("halt refuse", file_wr.we, 1'b0);
    wake <= 1'b1;
    for (int i = 0; i < 8 && busy !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    wake <= 1'b0;
    chk("wake busy", busy, 1'b0);
    chk("wake osc", osc_stop, 1'b0);
    $display("test sleep done");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // The whole run needs about a hundred cycles; the ceiling leaves wide margin.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    err_count = 0;
    checked = 0;
    cyc = 0;
    reset = 1'b1;
    instr = '0;
    file_rdata = 8'h00;
    stack_head = 11'h000;
    wake = 1'b0;
    wdog_tick = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_ret();
    t_sub();
    t_rot();
    t_sleep();
    wrap_up();
  end
endmodule
